// file: core/pixel_lut_params.svh
`ifndef PIXEL_LUT_PARAMS_SVH
`define PIXEL_LUT_PARAMS_SVH

// register byte addresses
`define ADDR_TABLE_CHOICE 4'h0
`define ADDR_TABLE_ENTRY_POINTER 4'h4
`define ADDR_TABLE_ENTRY_CONTENT 4'h8
`define ADDR_TABLE_MAPPING_ON 4'hc

// field positions
`define MAPPING_ON_BIT 0
`define CHOICE_BIT 0

// reset values
`define RST_TABLE_CHOICE 1'h0
`define RST_ENTRY_POINTER 10'h000
`define RST_MAPPING_ON 1'h0

// table geometry
`define TABLE_DEPTH 1024
`define TOP_SAMPLE 10'h3ff
`define LAST_USED_ENTRY 10'h3fe

`endif

// file: core/pixel_lut_pkg.sv
package pixel_lut_pkg;

    typedef enum logic [0:0] {
        luminance_table_choice = 1'b0
    } table_choice_e;

    typedef struct packed {
        logic valid;
        logic [9:0] value;
    } raw_pixel_s;

    typedef struct packed {
        logic valid;
        logic [7:0] value;
    } out_pixel_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic write;
        logic read;
    } reg_req_s;

endpackage

// file: core/pixel_luminance_table_10bit.sv
// How it works
// RULE_01 - Each pixel enters as 10 bits and leaves as 8 bits by dropping the two lowest bits.
// RULE_02 - With mapping on, each 10-bit sample is replaced by a 10-bit table value first.
// RULE_03 - The table holds 1024 entries indexed 0 to 1023.
// RULE_04 - Even samples use the entry at their own index and odd entries are never read; the code still reads one on a content read at an odd pointer.
// RULE_05 - Odd samples below the top take the midpoint of the lower and upper even entries.
// RULE_06 - Sample 1023 outputs entry 1022 directly.
// RULE_07 - Software writes the pointer first and a content write then lands at that pointer.
// RULE_08 - With mapping off the output is the raw sample truncated.
// RULE_09 - The selector offers only the luminance table, to which pointer and content apply.
// RULE_10 - After reset mapping is off.
`include "pixel_lut_params.svh"
`timescale 1ns/1ns
`default_nettype none

module pixel_luminance_table_10bit #(
    parameter int DEPTH = `TABLE_DEPTH
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire pixel_lut_pkg::raw_pixel_s PIX_IN,
    output pixel_lut_pkg::out_pixel_s PIX_OUT,
    input wire pixel_lut_pkg::reg_req_s REG_REQ,
    output logic [31:0] REG_RDATA
);
    import pixel_lut_pkg::*;

    logic [9:0] table_mem [0:DEPTH-1];
    logic [9:0] table_entry_pointer;
    logic table_mapping_on;
    table_choice_e table_choice;

    // stage 1 registers
    logic s1_valid;
    logic [9:0] s1_raw;
    logic s1_interp;
    logic [9:0] s1_lo;
    logic [9:0] s1_hi;
    logic s1_map;

    logic [9:0] even_lo_idx;
    logic [9:0] even_hi_idx;
    logic sample_odd;
    logic sample_top;
    logic [10:0] sum_lo_hi;
    logic [9:0] mapped;
    logic [9:0] final_value;

    // table writes at selected pointer
    always_ff @(posedge CLK_SYS) begin
        if (REG_REQ.write && REG_REQ.addr == `ADDR_TABLE_ENTRY_CONTENT
            && table_choice == luminance_table_choice) begin
            table_mem[table_entry_pointer] <= REG_REQ.wdata[9:0]; // see RULE_07 see RULE_03
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            table_entry_pointer <= `RST_ENTRY_POINTER;
        end else if (REG_REQ.write && REG_REQ.addr == `ADDR_TABLE_ENTRY_POINTER) begin
            table_entry_pointer <= REG_REQ.wdata[9:0]; // see RULE_07
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            table_mapping_on <= `RST_MAPPING_ON; // see RULE_10
        end else if (REG_REQ.write && REG_REQ.addr == `ADDR_TABLE_MAPPING_ON) begin
            table_mapping_on <= REG_REQ.wdata[`MAPPING_ON_BIT];
        end
    end

    // only one selectable table, so the selector always holds luminance
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            table_choice <= luminance_table_choice;
        end else if (REG_REQ.write && REG_REQ.addr == `ADDR_TABLE_CHOICE) begin
            table_choice <= luminance_table_choice; // see RULE_09
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_REQ.read) begin
            unique case (REG_REQ.addr)
                `ADDR_TABLE_CHOICE: REG_RDATA <= {31'h00000000, table_choice};
                `ADDR_TABLE_ENTRY_POINTER: REG_RDATA <= {22'h000000, table_entry_pointer};
                `ADDR_TABLE_ENTRY_CONTENT:
                    REG_RDATA <= {22'h000000, table_mem[table_entry_pointer]};
                `ADDR_TABLE_MAPPING_ON: REG_RDATA <= {31'h00000000, table_mapping_on};
                default: REG_RDATA <= 32'h00000000;
            endcase
        end else begin
            REG_RDATA <= 32'h00000000;
        end
    end

    // neighbour indices are always even
    always_comb begin
        sample_odd = PIX_IN.value[0];
        sample_top = (PIX_IN.value == `TOP_SAMPLE);
        even_lo_idx = {PIX_IN.value[9:1], 1'b0}; // see RULE_04
        even_hi_idx = sample_top ? `LAST_USED_ENTRY
                                 : 10'({PIX_IN.value[9:1], 1'b0} + 10'h002); // see RULE_06
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            s1_valid <= 1'b0;
            s1_raw <= 10'h000;
            s1_interp <= 1'b0;
            s1_map <= 1'b0;
        end else begin
            s1_valid <= PIX_IN.valid;
            s1_raw <= PIX_IN.value;
            s1_interp <= sample_odd && !sample_top; // see RULE_05
            s1_map <= table_mapping_on;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        s1_lo <= table_mem[even_lo_idx];
        s1_hi <= table_mem[even_hi_idx];
    end

    always_comb begin
        sum_lo_hi = {1'b0, s1_lo} + {1'b0, s1_hi};
        mapped = s1_interp ? sum_lo_hi[10:1] : s1_lo; // see RULE_05 see RULE_06
        final_value = s1_map ? mapped : s1_raw; // see RULE_02 see RULE_08
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            PIX_OUT <= '0;
        end else begin
            PIX_OUT.valid <= s1_valid;
            PIX_OUT.value <= final_value[9:2]; // see RULE_01
        end
    end

    // pixel path checks
    a_unmapped_pass: assert property ( // see RULE_08
        @(posedge CLK_SYS) disable iff (RESET)
        PIX_IN.valid && !table_mapping_on
        |-> ##2 PIX_OUT.value == $past(PIX_IN.value, 2) >> 2)
        else $error("unmapped pixel wrong");
    a_output_valid_lat: assert property ( // see RULE_01
        @(posedge CLK_SYS) disable iff (RESET)
        PIX_IN.valid |-> ##2 PIX_OUT.valid)
        else $error("pixel lost");
    a_output_idle: assert property ( // see RULE_01
        @(posedge CLK_SYS) disable iff (RESET)
        !PIX_IN.valid |-> ##2 !PIX_OUT.valid)
        else $error("spurious pixel");
    a_even_direct: assert property ( // see RULE_04
        @(posedge CLK_SYS) disable iff (RESET)
        PIX_IN.valid && table_mapping_on && !PIX_IN.value[0]
        |=> final_value == $past(table_mem[PIX_IN.value]))
        else $error("even sample not direct");
    a_odd_interp: assert property ( // see RULE_05
        @(posedge CLK_SYS) disable iff (RESET)
        PIX_IN.valid && table_mapping_on && PIX_IN.value[0] && PIX_IN.value != `TOP_SAMPLE
        |=> final_value == 10'((11'($past(table_mem[PIX_IN.value - 10'h001]))
            + 11'($past(table_mem[PIX_IN.value + 10'h001]))) >> 1))
        else $error("interpolation wrong");
    a_top_no_interp: assert property ( // see RULE_06
        @(posedge CLK_SYS) disable iff (RESET)
        PIX_IN.valid && PIX_IN.value == `TOP_SAMPLE |=> !s1_interp)
        else $error("top sample interpolated");
    a_top_last_entry: assert property ( // see RULE_06
        @(posedge CLK_SYS) disable iff (RESET)
        PIX_IN.valid && table_mapping_on && PIX_IN.value == `TOP_SAMPLE
        |=> final_value == $past(table_mem[`LAST_USED_ENTRY]))
        else $error("top sample not last entry");
    a_even_idx_only: assert property ( // see RULE_04
        @(posedge CLK_SYS) disable iff (RESET)
        !even_lo_idx[0] && !even_hi_idx[0])
        else $error("odd entry read");

    // register path checks
    a_pointer_write: assert property ( // see RULE_07
        @(posedge CLK_SYS) disable iff (RESET)
        REG_REQ.write && REG_REQ.addr == `ADDR_TABLE_ENTRY_POINTER
        |=> table_entry_pointer == $past(REG_REQ.wdata[9:0]))
        else $error("pointer not stored");
    a_content_write: assert property ( // see RULE_07
        @(posedge CLK_SYS) disable iff (RESET)
        REG_REQ.write && REG_REQ.addr == `ADDR_TABLE_ENTRY_CONTENT
        |=> table_mem[table_entry_pointer] == $past(REG_REQ.wdata[9:0]))
        else $error("content not stored");
    a_content_read: assert property ( // see RULE_07
        @(posedge CLK_SYS) disable iff (RESET)
        REG_REQ.read && REG_REQ.addr == `ADDR_TABLE_ENTRY_CONTENT
        |=> REG_RDATA[9:0] == $past(table_mem[table_entry_pointer]))
        else $error("content read wrong");
    a_choice_fixed: assert property ( // see RULE_09
        @(posedge CLK_SYS) disable iff (RESET)
        table_choice == luminance_table_choice)
        else $error("bad table choice");
    a_mapping_enable: assert property ( // see RULE_02
        @(posedge CLK_SYS) disable iff (RESET)
        REG_REQ.write && REG_REQ.addr == `ADDR_TABLE_MAPPING_ON
        |=> table_mapping_on == $past(REG_REQ.wdata[0]))
        else $error("enable not stored");
    a_reset_off: assert property ( // see RULE_10
        @(posedge CLK_SYS)
        $fell(RESET) |-> !table_mapping_on)
        else $error("mapping on after reset");

    // cover points
    c_mapped_odd: cover property (@(posedge CLK_SYS) disable iff (RESET)
        s1_map && s1_interp && s1_valid);
    c_mapped_even: cover property (@(posedge CLK_SYS) disable iff (RESET)
        s1_map && !s1_interp && s1_valid);
    c_mapped_top: cover property (@(posedge CLK_SYS) disable iff (RESET)
        s1_map && s1_valid && s1_raw == `TOP_SAMPLE);
    c_unmapped: cover property (@(posedge CLK_SYS) disable iff (RESET)
        !s1_map && s1_valid);
    c_load_then_on: cover property (@(posedge CLK_SYS) disable iff (RESET)
        REG_REQ.write && REG_REQ.addr == `ADDR_TABLE_ENTRY_CONTENT ##[1:100] table_mapping_on);

endmodule // pixel_luminance_table_10bit

`default_nettype wire

// file: verif/adc_source.sv
`timescale 1ns/1ns
`default_nettype none

module adc_source
(
    input wire logic clk_sys,
    input wire logic send,
    input wire logic [9:0] sample,
    output pixel_lut_pkg::raw_pixel_s pix
);
    import pixel_lut_pkg::*;
    logic [9:0] last = 10'h155;
    always @(posedge clk_sys) begin
        if (send) begin
            last <= sample;
        end
    end
    // idle lines carry the inverse of the last sample
    assign pix.valid = send;
    assign pix.value = send ? sample : ~last;
endmodule // adc_source

`default_nettype wire

// file: verif/pixel_luminance_table_10bit_tb.sv
`include "pixel_lut_params.svh"
`timescale 1ns/1ns
`default_nettype none

module pixel_luminance_table_10bit_tb;
    import pixel_lut_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    reg_req_s req = '0;
    logic send = 1'b0;
    logic [9:0] sample = 10'h000;
    raw_pixel_s pix_in;
    out_pixel_s pix_out;
    logic [31:0] reg_rdata;
    logic [9:0] tbl [int];
    logic en = 1'b0;
    logic [9:0] idx [7] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h3fe, 10'h3ff};
    logic [9:0] val [7] = '{10'h100, 10'h3ff, 10'h200, 10'h000, 10'h305, 10'h2c4, 10'h011};
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    adc_source u_adc_source (.clk_sys(clk_sys), .send(send), .sample(sample), .pix(pix_in));
    pixel_luminance_table_10bit u_pixel_luminance_table_10bit (.CLK_SYS(clk_sys),
        .RESET(reset), .PIX_IN(pix_in), .PIX_OUT(pix_out), .REG_REQ(req), .REG_RDATA(reg_rdata));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge clk_sys);
        req <= '0;
        #1;
    endtask
    task automatic rd_check(input string name, input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
        @(posedge clk_sys);
        req <= '0;
        #1;
        check(name, reg_rdata, exp);
    endtask
    task automatic px(input logic [9:0] v);
        logic [9:0] m;
        @(posedge clk_sys);
        send <= 1'b1;
        sample <= v;
        @(posedge clk_sys);
        send <= 1'b0;
        @(posedge clk_sys);
        #1;
        m = !en ? v : (v == `TOP_SAMPLE) ? tbl[1022] :
            v[0] ? 10'((11'(tbl[v - 1]) + 11'(tbl[v + 1])) >> 1) : tbl[v];
        check("pix valid", pix_out.valid, 1'b1);
        check("pix value", pix_out.value, m[9:2]);
        @(posedge clk_sys);
        #1;
        check("pix idle", pix_out.valid, 1'b0);
    endtask
    task automatic after_reset();
        rd_check("mapping on", `ADDR_TABLE_MAPPING_ON, 32'h0);
        rd_check("pointer", `ADDR_TABLE_ENTRY_POINTER, 32'h0);
        px(10'h3ff);
        px(10'h2a5);
    endtask
    task automatic load_table();
        for (int i = 0; i < 7; i++) begin
            wr(`ADDR_TABLE_ENTRY_POINTER, {22'h0, idx[i]});
            wr(`ADDR_TABLE_ENTRY_CONTENT, {22'h0, val[i]});
            tbl[idx[i]] = val[i];
        end
        for (int i = 6; i >= 0; i--) begin
            wr(`ADDR_TABLE_ENTRY_POINTER, {22'h0, idx[i]});
            rd_check("content", `ADDR_TABLE_ENTRY_CONTENT, {22'h0, val[i]});
        end
        wr(`ADDR_TABLE_CHOICE, 32'h1);
        rd_check("choice", `ADDR_TABLE_CHOICE, 32'h0);
        rd_check("unmapped", 4'h1, 32'h0);
    endtask
    task automatic mapped_pixels();
        wr(`ADDR_TABLE_MAPPING_ON, 32'h1);
        en = 1'b1;
        rd_check("mapping on", `ADDR_TABLE_MAPPING_ON, 32'h1);
        for (int i = 0; i < 7; i++) begin
            px(idx[i]);
        end
        wr(`ADDR_TABLE_MAPPING_ON, 32'h0);
        en = 1'b0;
        px(10'h003);
    endtask
    task automatic reset_mid_run();
        wr(`ADDR_TABLE_MAPPING_ON, 32'h1);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        en = 1'b0;
        rd_check("mapping after reset", `ADDR_TABLE_MAPPING_ON, 32'h0);
        px(10'h0c7);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        after_reset();
        load_table();
        mapped_pixels();
        reset_mid_run();
        tally_and_finish();
    end
endmodule // pixel_luminance_table_10bit_tb

`default_nettype wire
